// file: shared/pfs_cfg.svh
// pfs_cfg.svh: offsets, field positions, reset values and timing figures
// of the program flash self-access controller.
// assumes: included by its bare name in the package and the design files.
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH

// register byte offsets on the AXI4-Lite port
`define PFS_OFS_ADDR_LOW   8'h00
`define PFS_OFS_ADDR_HIGH  8'h04
`define PFS_OFS_DATA_LOW   8'h08
`define PFS_OFS_DATA_HIGH  8'h0C
`define PFS_OFS_CONTROL    8'h10
`define PFS_OFS_UNLOCK_KEY 8'h14

// nvm_control_reg bit positions
`define PFS_BIT_READ_TRIG    0
`define PFS_BIT_WRITE_TRIG   1
`define PFS_BIT_PERMIT       2
`define PFS_BIT_ERASE_SEL    4
`define PFS_BIT_LATCH_ONLY   5
`define PFS_BIT_CONFIG_SEL   6
`define PFS_BIT_PROGRAM_SEL  7
`define PFS_BIT_BUSY         8

// unlock key pair
`define PFS_KEY_FIRST  8'h55
`define PFS_KEY_SECOND 8'hAA

// flash geometry
`define PFS_WORD_BITS  14
`define PFS_ADDR_BITS  15
`define PFS_ROW_WORDS  32
`define PFS_ERASED_WORD 14'h3FFF

// write-protect segment ends, exclusive, per write_protect_range code
`define PFS_WP_END_10  15'h0200
`define PFS_WP_END_01  15'h1000
`define PFS_WP_END_00  15'h2000

// timing
`define PFS_CLK_MHZ      125
`define PFS_STALL_MS     2
`define PFS_SETUP_CYCLES 2
`define PFS_STALL_CYCLES (`PFS_STALL_MS * `PFS_CLK_MHZ * 1000)

// bus answers
`define PFS_RESP_OKAY   2'h0
`define PFS_RESP_SLVERR 2'h2

`endif

// file: shared/pfs_pkg.sv
// pfs_pkg: types shared by the program flash self-access controller.
// assumes: pfs_cfg.svh on the include path.
`include "pfs_cfg.svh"

package pfs_pkg;

  // one-cycle command pulses toward the flash array
  typedef struct packed {
    logic                        rdEn;
    logic                        eraseEn;
    logic                        progEn;
    logic [`PFS_ADDR_BITS-1:0]   addr;
    logic [`PFS_WORD_BITS-1:0]   data;
  } pfs_flash_req_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_RD1,
    PH_RD2,
    PH_SETUP,
    PH_STREAM,
    PH_HOLD
  } pfs_phase_t;

endpackage

// file: rtl/pfs_latch_bank.sv
// pfs_latch_bank: the block of write latches that feeds one flash program.
// assumes: one clock, async active-low reset; clear wins over load.
`timescale 1ns/10ps
`include "pfs_cfg.svh"

module pfs_latch_bank #(
  parameter int WORDS = `PFS_ROW_WORDS
) (
  input  wire logic                              sys_clk,   // clock
  input  wire logic                              reset_n,   // async reset
  input  wire logic                              loadEn,    // write one latch
  input  wire logic [$clog2(WORDS)-1:0]          loadIdx,   // latch index
  input  wire logic [`PFS_WORD_BITS-1:0]         loadData,  // word to hold
  input  wire logic                              clearAll,  // back to erased
  input  wire logic [$clog2(WORDS)-1:0]          rdIdx,     // read index
  output logic      [`PFS_WORD_BITS-1:0]         rdData     // latch content
);
  import pfs_pkg::*;

  typedef struct packed {
    logic [WORDS-1:0][`PFS_WORD_BITS-1:0] words;
  } pfs_latch_state_t;

  pfs_latch_state_t s;
  pfs_latch_state_t next_s;

  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++)
    begin : g_word
      // one driver per word slice, so no two processes share next_s
      assign next_s.words[gi] = clearAll ? `PFS_ERASED_WORD
                              : (loadEn && loadIdx == gi) ? loadData
                              : s.words[gi];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      s <= {WORDS{`PFS_ERASED_WORD}};
    else
      s <= next_s;
  end

  assign rdData = s.words[rdIdx];

endmodule

// file: rtl/pfs_ctrl.sv
// pfs_ctrl: program flash self-access controller with AXI4-Lite registers.
// assumes: sys_clk is the processor instruction clock, one instruction per
// cycle; the flash array answers a read combinationally in the cycle of
// its read pulse; flash protection inputs are synchronous and static.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "pfs_cfg.svh"

// How it works
// - fetch takes the second cycle after read trigger; that slot is dropped
// - fetched word lands in the data register pair the very next cycle
// - data registers keep the word until another read or a software write
// - reads work whatever the code guard setting
// - flash erase is by whole 32-word rows only
// - erase select clears itself when the row erase finishes
// - two set-up cycles follow the write trigger before the stall
// - row erase stalls the processor about 2 ms; clocks keep running
// - execution resumes at the third instruction after the trigger
// - programming never erases anything by itself
// - one program writes only the aligned latch block, never crossing it
// - every write latch returns to 3FFFh when programming completes
// - latch-only set: trigger just loads the addressed latch, no stall
// - latch-only clear: trigger loads last latch then programs the block
// - the whole latch block is written, loaded or not
// - the 2 ms stall happens only for the real flash write
// - 14-bit words; 32-word rows and latch blocks, low five bits zero
// - write trigger refused unless write permit already set
// - erase or program refused inside the write-protected segment
module pfs_ctrl
  import pfs_pkg::*;
#(
  parameter int STALL_CYCLES = `PFS_STALL_CYCLES
) (
  input  wire logic                        sys_clk,            // clock
  input  wire logic                        reset_n,            // async reset
  input  wire logic [7:0]                  s_axi_awaddr,       // write addr
  input  wire logic                        s_axi_awvalid,      // addr valid
  output logic                             s_axi_awready,      // addr ready
  input  wire logic [31:0]                 s_axi_wdata,        // write data
  input  wire logic [3:0]                  s_axi_wstrb,        // byte lanes
  input  wire logic                        s_axi_wvalid,       // data valid
  output logic                             s_axi_wready,       // data ready
  output logic [1:0]                       s_axi_bresp,        // write resp
  output logic                             s_axi_bvalid,       // resp valid
  input  wire logic                        s_axi_bready,       // resp ready
  input  wire logic [7:0]                  s_axi_araddr,       // read addr
  input  wire logic                        s_axi_arvalid,      // addr valid
  output logic                             s_axi_arready,      // addr ready
  output logic [31:0]                      s_axi_rdata,        // read data
  output logic [1:0]                       s_axi_rresp,        // read resp
  output logic                             s_axi_rvalid,       // data valid
  input  wire logic                        s_axi_rready,       // data ready
  input  wire logic [1:0]                  write_protect_range, // wp code
  input  wire logic [`PFS_WORD_BITS-1:0]   flashRdData,        // array word
  output pfs_pkg::pfs_flash_req_t          flashReq,           // to array
  output logic                             cpuStall,           // halt core
  output logic                             cpuSkip             // drop slot
);
  import pfs_pkg::*;

  localparam int CW = $clog2(STALL_CYCLES + 1);
  localparam int IW = $clog2(`PFS_ROW_WORDS);

  typedef struct packed {
    logic                        awReady;
    logic                        wReady;
    logic                        bValid;
    logic [1:0]                  bResp;
    logic                        arReady;
    logic                        rValid;
    logic [31:0]                 rData;
    logic [1:0]                  rResp;
    logic                        awHave;
    logic [7:0]                  awAddr;
    logic                        wHave;
    logic [31:0]                 wData;
    logic [3:0]                  wStrb;
    logic [7:0]                  addrLow;
    logic [6:0]                  addrHigh;
    logic [7:0]                  dataLow;
    logic [5:0]                  dataHigh;
    logic                        rdTrig;
    logic                        wrTrig;
    logic                        permit;
    logic                        eraseSel;
    logic                        latchOnly;
    logic                        cfgSel;
    logic                        progSel;
    logic [1:0]                  keyStage;
    pfs_phase_t                  phase;
    logic [CW-1:0]               cnt;
    logic [IW-1:0]               wordIdx;
    logic                        isErase;
    pfs_flash_req_t              flash;
    logic                        stall;
    logic                        skip;
  } pfs_ctrl_state_t;

  pfs_ctrl_state_t s;
  pfs_ctrl_state_t next_s;

  logic                        latchLoad;
  logic                        latchClear;
  logic [`PFS_WORD_BITS-1:0]   latchRdData;
  logic [`PFS_ADDR_BITS-1:0]   curAddr;
  logic [`PFS_WORD_BITS-1:0]   curData;

  assign curAddr = {s.addrHigh, s.addrLow};
  assign curData = {s.dataHigh, s.dataLow};

  // true when the address falls in the segment the protect code guards
  function automatic logic isGuarded(input logic [`PFS_ADDR_BITS-1:0] a,
                                     input logic [1:0] code);
    logic hit;
    hit = 1'b0;
    case (code)
      2'h2:    hit = (a < `PFS_WP_END_10);
      2'h1:    hit = (a < `PFS_WP_END_01);
      2'h0:    hit = (a < `PFS_WP_END_00);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  pfs_latch_bank #(
    .WORDS    (`PFS_ROW_WORDS)
  ) u_latches (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .loadEn   (latchLoad),
    .loadIdx  (s.addrLow[IW-1:0]),
    .loadData (curData),
    .clearAll (latchClear),
    .rdIdx    (s.wordIdx),
    .rdData   (latchRdData)
  );

  always_comb
  begin
    logic        doWrite;
    logic        wantRd;
    logic        wantWr;
    logic        ok;
    logic [7:0]  wb;
    doWrite = 1'b0;
    wantRd = 1'b0;
    wantWr = 1'b0;
    ok = 1'b0;
    wb = 8'h00;
    next_s = s;
    latchLoad = 1'b0;
    latchClear = 1'b0;
    next_s.flash.rdEn = 1'b0;
    next_s.flash.eraseEn = 1'b0;
    next_s.flash.progEn = 1'b0;
    next_s.skip = 1'b0;

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && s.awReady)
    begin
      next_s.awHave = 1'b1;
      next_s.awAddr = s_axi_awaddr;
      next_s.awReady = 1'b0;
    end
    if (s_axi_wvalid && s.wReady)
    begin
      next_s.wHave = 1'b1;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
      next_s.wReady = 1'b0;
    end
    if (s.bValid && s_axi_bready)
    begin
      next_s.bValid = 1'b0;
      next_s.awReady = 1'b1;
      next_s.wReady = 1'b1;
    end

    doWrite = s.awHave && s.wHave && !s.bValid;
    wb = s.wData[7:0];
    if (doWrite)
    begin
      next_s.awHave = 1'b0;
      next_s.wHave = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp = `PFS_RESP_OKAY;
      case (s.awAddr)
        `PFS_OFS_ADDR_LOW:
          if (s.wStrb[0])
            next_s.addrLow = wb;
        `PFS_OFS_ADDR_HIGH:
          if (s.wStrb[0])
            next_s.addrHigh = wb[6:0];
        `PFS_OFS_DATA_LOW:
          if (s.wStrb[0])
            next_s.dataLow = wb;
        `PFS_OFS_DATA_HIGH:
          if (s.wStrb[0])
            next_s.dataHigh = wb[5:0];
        `PFS_OFS_UNLOCK_KEY:
          if (s.wStrb[0])
          begin
            // a stray value between the two halves throws the key away
            if (wb == `PFS_KEY_FIRST)
              next_s.keyStage = 2'h1;
            else if (wb == `PFS_KEY_SECOND && s.keyStage == 2'h1)
              next_s.keyStage = 2'h2;
            else
              next_s.keyStage = 2'h0;
          end
        `PFS_OFS_CONTROL:
          // control is frozen while an operation runs
          if (s.wStrb[0] && s.phase == PH_IDLE)
          begin
            next_s.permit = wb[`PFS_BIT_PERMIT];
            next_s.eraseSel = wb[`PFS_BIT_ERASE_SEL];
            next_s.latchOnly = wb[`PFS_BIT_LATCH_ONLY];
            next_s.cfgSel = wb[`PFS_BIT_CONFIG_SEL];
            next_s.progSel = wb[`PFS_BIT_PROGRAM_SEL];
            wantWr = wb[`PFS_BIT_WRITE_TRIG];
            wantRd = wb[`PFS_BIT_READ_TRIG] && !wantWr;
          end
        default:
          next_s.bResp = `PFS_RESP_SLVERR;
      endcase
    end

    // read trigger: no code guard term on purpose
    if (wantRd && next_s.progSel && !next_s.cfgSel)
    begin
      next_s.rdTrig = 1'b1;
      next_s.phase = PH_RD1;
    end

    if (wantWr)
    begin
      // permit is the value held before this write
      ok = s.permit && s.keyStage == 2'h2
        && next_s.progSel && !next_s.cfgSel
        && !isGuarded(curAddr, write_protect_range);
      next_s.keyStage = 2'h0;
      if (ok)
      begin
        next_s.cnt = '0;
        if (next_s.eraseSel)
        begin
          next_s.wrTrig = 1'b1;
          next_s.isErase = 1'b1;
          next_s.phase = PH_SETUP;
        end
        else if (next_s.latchOnly)
          latchLoad = 1'b1;
        else
        begin
          latchLoad = 1'b1;
          next_s.wrTrig = 1'b1;
          next_s.isErase = 1'b0;
          next_s.phase = PH_SETUP;
        end
      end
    end

    case (s.phase)
      PH_IDLE:
        next_s.stall = 1'b0;
      PH_RD1:
      begin
        next_s.phase = PH_RD2;
        next_s.flash.rdEn = 1'b1;
        next_s.flash.addr = curAddr;
        next_s.skip = 1'b1;
      end
      PH_RD2:
      begin
        // array answers during the read pulse; visible next cycle
        next_s.dataLow = flashRdData[7:0];
        next_s.dataHigh = flashRdData[13:8];
        next_s.rdTrig = 1'b0;
        next_s.phase = PH_IDLE;
      end
      PH_SETUP:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CW'(`PFS_SETUP_CYCLES - 1))
        begin
          next_s.cnt = '0;
          next_s.stall = 1'b1;
          next_s.wordIdx = '0;
          if (s.isErase)
          begin
            next_s.flash.eraseEn = 1'b1;
            next_s.flash.addr = {curAddr[14:5], 5'h00};
            next_s.phase = PH_HOLD;
          end
          else
            next_s.phase = PH_STREAM;
        end
      end
      PH_STREAM:
      begin
        // every latch goes out, loaded or not; no erase pulse here
        next_s.flash.progEn = 1'b1;
        next_s.flash.addr = {curAddr[14:5], s.wordIdx};
        next_s.flash.data = latchRdData;
        next_s.wordIdx = s.wordIdx + 1'b1;
        if (s.wordIdx == IW'(`PFS_ROW_WORDS - 1))
          next_s.phase = PH_HOLD;
      end
      PH_HOLD:
      begin
        next_s.cnt = s.cnt + 1'b1;
        if (s.cnt == CW'(STALL_CYCLES - 1))
        begin
          next_s.stall = 1'b0;
          next_s.wrTrig = 1'b0;
          next_s.phase = PH_IDLE;
          if (s.isErase)
            next_s.eraseSel = 1'b0;
          else
            latchClear = 1'b1;
        end
      end
      default:
        next_s.phase = PH_IDLE;
    endcase

    // register reads; a read taken with a trigger write shows the old value
    if (s.rValid && s_axi_rready)
    begin
      next_s.rValid = 1'b0;
      next_s.arReady = 1'b1;
    end
    if (s_axi_arvalid && s.arReady)
    begin
      next_s.arReady = 1'b0;
      next_s.rValid = 1'b1;
      next_s.rResp = `PFS_RESP_OKAY;
      next_s.rData = 32'h0000_0000;
      case (s_axi_araddr)
        `PFS_OFS_ADDR_LOW:   next_s.rData[7:0] = s.addrLow;
        `PFS_OFS_ADDR_HIGH:  next_s.rData[6:0] = s.addrHigh;
        `PFS_OFS_DATA_LOW:   next_s.rData[7:0] = s.dataLow;
        `PFS_OFS_DATA_HIGH:  next_s.rData[5:0] = s.dataHigh;
        `PFS_OFS_UNLOCK_KEY: next_s.rData = 32'h0000_0000;
        `PFS_OFS_CONTROL:
        begin
          next_s.rData[`PFS_BIT_READ_TRIG] = s.rdTrig;
          next_s.rData[`PFS_BIT_WRITE_TRIG] = s.wrTrig;
          next_s.rData[`PFS_BIT_PERMIT] = s.permit;
          next_s.rData[`PFS_BIT_ERASE_SEL] = s.eraseSel;
          next_s.rData[`PFS_BIT_LATCH_ONLY] = s.latchOnly;
          next_s.rData[`PFS_BIT_CONFIG_SEL] = s.cfgSel;
          next_s.rData[`PFS_BIT_PROGRAM_SEL] = s.progSel;
          next_s.rData[`PFS_BIT_BUSY] = (s.phase != PH_IDLE);
        end
        default:             next_s.rResp = `PFS_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s <= '0;
      s.awReady <= 1'b1;
      s.wReady <= 1'b1;
      s.arReady <= 1'b1;
      s.phase <= PH_IDLE;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awReady;
  assign s_axi_wready = s.wReady;
  assign s_axi_bvalid = s.bValid;
  assign s_axi_bresp = s.bResp;
  assign s_axi_arready = s.arReady;
  assign s_axi_rvalid = s.rValid;
  assign s_axi_rdata = s.rData;
  assign s_axi_rresp = s.rResp;
  assign flashReq = s.flash;
  assign cpuStall = s.stall;
  assign cpuSkip = s.skip;

endmodule

// file: testbench/pfs_ctrl_monitor.sv
// pfs_ctrl_monitor: timing checks on the flash command and stall ports.
// assumes: bound to pfs_ctrl; sees only its ports.
`timescale 1ns/10ps
`include "pfs_cfg.svh"

module pfs_ctrl_monitor
#(
  parameter int STALL_CYCLES = 20
) (
  input wire logic                    sys_clk,             // clock
  input wire logic                    reset_n,             // async reset
  input wire logic [7:0]              s_axi_awaddr,        // write addr
  input wire logic                    s_axi_awvalid,       // addr valid
  input wire logic                    s_axi_awready,       // addr ready
  input wire logic [31:0]             s_axi_wdata,         // write data
  input wire logic [3:0]              s_axi_wstrb,         // lanes
  input wire logic                    s_axi_wvalid,        // data valid
  input wire logic                    s_axi_wready,        // data ready
  input wire logic [1:0]              s_axi_bresp,         // write resp
  input wire logic                    s_axi_bvalid,        // resp valid
  input wire logic                    s_axi_bready,        // resp ready
  input wire logic [7:0]              s_axi_araddr,        // read addr
  input wire logic                    s_axi_arvalid,       // addr valid
  input wire logic                    s_axi_arready,       // addr ready
  input wire logic [31:0]             s_axi_rdata,         // read data
  input wire logic [1:0]              s_axi_rresp,         // read resp
  input wire logic                    s_axi_rvalid,        // data valid
  input wire logic                    s_axi_rready,        // data ready
  input wire logic [1:0]              write_protect_range, // wp code
  input wire logic [`PFS_WORD_BITS-1:0] flashRdData,       // array word
  input wire pfs_pkg::pfs_flash_req_t flashReq,            // to array
  input wire logic                    cpuStall,            // halt core
  input wire logic                    cpuSkip              // drop slot
);
  import pfs_pkg::*;
  int   stallLen;
  int   progRun;
  logic wasProg;

  // lengths of the current stall and program burst, in cycles
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stallLen <= 0;
      progRun  <= 0;
      wasProg  <= 1'b0;
    end
    else
    begin
      stallLen <= cpuStall ? stallLen + 1 : 0;
      progRun  <= flashReq.progEn ? progRun + 1 : 0;
      wasProg  <= cpuStall && (wasProg || flashReq.progEn);
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  skip_marks_fetch_a: assert property (cpuSkip |-> flashReq.rdEn)
    else $error("skipped slot without flash fetch");
  skip_single_a: assert property (cpuSkip |=> !cpuSkip)
    else $error("skip longer than one cycle");
  erase_row_base_a: assert property (flashReq.eraseEn |->
    flashReq.addr[4:0] == 5'h00 && cpuStall)
    else $error("erase not on a stalled row base");
  // program stall: the 32 streaming cycles plus the hold count
  stall_length_a: assert property ($fell(cpuStall) |->
    stallLen == (wasProg ? STALL_CYCLES + 32 : STALL_CYCLES))
    else $error("stall length wrong");
  stall_start_a: assert property ($rose(cpuStall) |->
    (flashReq.eraseEn) or (##1 flashReq.progEn))
    else $error("stall without flash write");
  prog_in_stall_a: assert property (flashReq.progEn |-> cpuStall)
    else $error("program pulse while core runs");
  prog_burst_a: assert property ($fell(flashReq.progEn) |->
    progRun == 32)
    else $error("program burst not 32 words");
  prog_index_a: assert property (flashReq.progEn |->
    flashReq.addr[4:0] == progRun[4:0])
    else $error("program word index out of order");
  prog_block_a: assert property (flashReq.progEn &&
    $past(flashReq.progEn) |-> $stable(flashReq.addr[14:5]))
    else $error("program crossed latch block");

  cover property (flashReq.eraseEn);
  cover property (flashReq.progEn ##1 !flashReq.progEn);
  cover property (cpuSkip);
endmodule

bind pfs_ctrl pfs_ctrl_monitor #(.STALL_CYCLES(STALL_CYCLES)) mon (.*);

// file: testbench/pfs_flash_model.sv
// pfs_flash_model: behavioural program flash array behind pfs_ctrl.
// assumes: one-cycle command pulses; content has no reset.
`timescale 1ns/10ps
`include "pfs_cfg.svh"

module pfs_flash_model (
  input  wire logic                    sys_clk,     // clock
  input  wire pfs_pkg::pfs_flash_req_t flashReq,    // commands
  output logic [`PFS_WORD_BITS-1:0]    flashRdData  // word out
);
  import pfs_pkg::*;
  logic [`PFS_WORD_BITS-1:0] mem [0:(1 << `PFS_ADDR_BITS)-1];

  initial
  begin
    for (int i = 0; i < (1 << `PFS_ADDR_BITS); i++)
      mem[i] = 14'(i) ^ 14'h2A5A;
  end

  // word valid only in the read pulse; otherwise show its inverse
  assign flashRdData = flashReq.rdEn ? mem[flashReq.addr]
                                     : ~mem[flashReq.addr];

  always @(posedge sys_clk)
  begin
    if (flashReq.eraseEn)
      for (int j = 0; j < `PFS_ROW_WORDS; j++)
        mem[{flashReq.addr[14:5], 5'(j)}] <= `PFS_ERASED_WORD;
    // programming only clears bits, so unerased words show it
    if (flashReq.progEn)
      mem[flashReq.addr] <= mem[flashReq.addr] & flashReq.data;
  end
endmodule

// file: testbench/pfs_ctrl_bench.sv
// pfs_ctrl_bench: register-level tests of the flash self-access block.
// assumes: pfs_ctrl, pfs_flash_model and the bound monitor are compiled.
`timescale 1ns/10ps
`include "pfs_cfg.svh"

module pfs_ctrl_bench;
  import pfs_pkg::*;
  localparam logic [7:0] AL = 8'h00, AH = 8'h04, DL = 8'h08, DH = 8'h0C;
  localparam logic [7:0] CTRL = 8'h10, KEY = 8'h14;
  logic        sys_clk, reset_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cpuStall, cpuSkip;
  logic [1:0]  s_axi_bresp, s_axi_rresp, write_protect_range, lastResp;
  logic [13:0] flashRdData;
  pfs_flash_req_t flashReq;
  int          failCount = 0;
  int          nTests = 0;
  int          stallSeen = 0;
  logic [31:0] rp [3] = '{32'h90, 32'h94, 32'h94};
  logic [15:0] rk [3] = '{16'h55AA, 16'h33AA, 16'h55AA};
  logic [1:0]  rw [3] = '{2'b11, 2'b11, 2'b10};
  logic [14:0] rr [3] = '{15'h0180, 15'h0180, 15'h0100};
  logic [14:0] ea [5] = '{15'h0120, 15'h013F, 15'h0160, 15'h011F, 15'h0140};

  pfs_ctrl #(.STALL_CYCLES(20)) uut (.*);
  pfs_flash_model fl (.*);

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // stalled cycles seen so far; refused or latch-only triggers add none
  always @(posedge sys_clk)
    if (cpuStall === 1'b1)
      stallSeen <= stallSeen + 1;

  function automatic logic [13:0] pat(input logic [14:0] a);
    return a[13:0] ^ 14'h2A5A;
  endfunction

  task automatic endOfTest();
    if (failCount == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp)
    begin
      failCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    lastResp = s_axi_bresp;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    lastResp = s_axi_rresp;
  endtask

  task automatic seta(input logic [14:0] a);
    wr(AL, {24'h0, a[7:0]});
    wr(AH, {25'h0, a[14:8]});
  endtask

  task automatic poll(input int b);
    logic [31:0] v;
    for (int n = 0; n < 400; n++)
    begin
      rd(CTRL, v);
      if (v[b] === 1'b0) break;
    end
    chk({31'h0, v[b]}, 32'h0);
  endtask

  // permit set first, then key pair, then trigger, then wait for idle
  task automatic go(input logic [31:0] pre, input logic [15:0] k,
                    input logic [31:0] c);
    wr(CTRL, pre);
    wr(KEY, {24'h0, k[15:8]});
    wr(KEY, {24'h0, k[7:0]});
    wr(CTRL, c);
    poll(8);
  endtask

  task automatic fr(input logic [14:0] a, input logic [13:0] e);
    logic [31:0] x, y;
    seta(a);
    wr(CTRL, 32'h81);
    // fetch slot and landing cycle pass before the data is read
    repeat (2) @(posedge sys_clk);
    rd(DL, x);
    rd(DH, y);
    chk({18'h0, y[5:0], x[7:0]}, {18'h0, e});
  endtask

  task automatic load(input logic [14:0] a, input logic [13:0] w,
                      input logic [31:0] c);
    seta(a);
    wr(DL, {24'h0, w[7:0]});
    wr(DH, {26'h0, w[13:8]});
    go(c & ~32'h2, 16'h55AA, c);
  endtask

  initial
  begin
    logic [31:0] v;
    reset_n = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    write_protect_range = 2'b11;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(CTRL, v);
    chk(v, 32'h0);
    rd(8'h18, v);
    chk({30'h0, lastResp}, 32'h2);
    wr(8'h18, 32'h1);
    chk({30'h0, lastResp}, 32'h2);
    fr(15'h0123, pat(15'h0123));
    wr(DL, 32'h5A);
    chk({30'h0, lastResp}, 32'h0);
    // a write without lane 0 must leave the register alone
    s_axi_wstrb <= 4'hE;
    wr(DL, 32'hA5);
    s_axi_wstrb <= 4'hF;
    rd(DL, v);
    chk(v, 32'h5A);
    rd(DH, v);
    chk(v, {26'h0, 6'(pat(15'h0123) >> 8)});
    for (int i = 0; i < 2; i++)
    begin
      seta(i ? 15'h0165 : 15'h0125);
      go(32'h94, 16'h55AA, 32'h96);
      poll(4);
    end
    for (int i = 0; i < 5; i++)
      fr(ea[i], i < 3 ? 14'h3FFF : pat(ea[i]));
    for (int i = 0; i < 3; i++)
    begin
      write_protect_range <= rw[i];
      seta(rr[i]);
      if (i == 1) wr(KEY, 32'h55);
      go(rp[i], rk[i], 32'h96);
      fr(rr[i], pat(rr[i]));
    end
    write_protect_range <= 2'b11;
    for (int i = 0; i < 3; i++)
      load(15'h0120 + 15'(i), 14'h0A50 + 14'(i), 32'hA6);
    // two erases of 20 stalled cycles each; nothing since
    chk(stallSeen, 32'h28);
    fr(15'h0120, 14'h3FFF);
    load(15'h0123, 14'h0A53, 32'h86);
    // 32 streaming cycles plus the 20-cycle hold
    chk(stallSeen, 32'h5C);
    for (int i = 0; i < 5; i++)
      fr(15'h0120 + 15'(i), i < 4 ? 14'h0A50 + 14'(i) : 14'h3FFF);
    load(15'h0167, 14'h0111, 32'h86);
    fr(15'h0160, 14'h3FFF);
    fr(15'h0167, 14'h0111);
    endOfTest();
  end

  initial
  begin
    #200000;
    failCount++;
    endOfTest();
  end
endmodule
